//--- core/pioc_defines.svh
`ifndef PIOC_DEFINES_SVH
`define PIOC_DEFINES_SVH

// Register byte offsets on the local register port.
`define PIOC_OFF_OWN_SET 8'h00
`define PIOC_OFF_OWN_CLR 8'h04
`define PIOC_OFF_OWN_STS 8'h08
`define PIOC_OFF_OE_SET 8'h10
`define PIOC_OFF_OE_CLR 8'h14
`define PIOC_OFF_OE_STS 8'h18
`define PIOC_OFF_FLT_SET 8'h20
`define PIOC_OFF_FLT_CLR 8'h24
`define PIOC_OFF_FLT_STS 8'h28
`define PIOC_OFF_OD_SET 8'h30
`define PIOC_OFF_OD_CLR 8'h34
`define PIOC_OFF_OD_STS 8'h38
`define PIOC_OFF_PIN_STS 8'h3C
`define PIOC_OFF_IRQ_EN 8'h40
`define PIOC_OFF_IRQ_DIS 8'h44
`define PIOC_OFF_IRQ_MSK 8'h48
`define PIOC_OFF_IRQ_STS 8'h4C
`define PIOC_OFF_MD_SET 8'h50
`define PIOC_OFF_MD_CLR 8'h54
`define PIOC_OFF_MD_STS 8'h58
`define PIOC_OFF_PU_DIS 8'h60
`define PIOC_OFF_PU_EN 8'h64
`define PIOC_OFF_PU_STS 8'h68
`define PIOC_OFF_SEL_A 8'h70
`define PIOC_OFF_SEL_B 8'h74
`define PIOC_OFF_SEL_STS 8'h78
`define PIOC_OFF_OW_SET 8'hA0
`define PIOC_OFF_OW_CLR 8'hA4
`define PIOC_OFF_OW_STS 8'hA8

// Reset values and line population.
`define PIOC_RST_ZERO 32'h0000_0000
`define PIOC_RST_OWN 32'h0000_0000
`define PIOC_ALL_LINES 32'hFFFF_FFFF

// Timing: clock period and the number of synchroniser stages a pin passes before any logic sees it.
`define PIOC_CLK_NS 20
`define PIOC_SYNC_STAGES 2

`endif

//--- core/pioc_pkg.sv
package pioc_pkg;

	// One bit per I/O line.
	typedef logic [31:0] pioc_vec_t;

	// Apply a set/clear register pair to a status vector; set wins over clear.
	function automatic pioc_vec_t pioc_setclr(input pioc_vec_t cur, input logic hit_set,
		input logic hit_clr, input pioc_vec_t d, input pioc_vec_t lines);
		pioc_vec_t r;
		r = cur;
		if (hit_clr) begin
			r = r & ~(d & lines);
		end
		if (hit_set) begin
			r = r | (d & lines);
		end
		return r;
	endfunction : pioc_setclr

endpackage : pioc_pkg

//--- core/pioc_in_if.sv
// Sampled pin levels passed between the input path and the controller core.
interface pioc_in_if;
	import pioc_pkg::*;
	pioc_vec_t raw;
	pioc_vec_t filt;
	pioc_vec_t filt_en;
	pioc_vec_t chg;
	logic clk_en;
	modport filt_mp (input filt_en, input clk_en, output raw, output filt);
	modport det_mp (input filt, input clk_en, output chg);
	modport ctl_mp (input raw, input filt, input chg, output filt_en, output clk_en);
endinterface : pioc_in_if

//--- core/pioc_in_filter.sv
`include "pioc_defines.svh"

// Pin synchroniser and per-line glitch filter.
module pioc_in_filter
	import pioc_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	input wire pioc_vec_t pad_in,
	pioc_in_if.filt_mp io
);

	pioc_vec_t sync1_reg;
	pioc_vec_t sync2_reg;
	pioc_vec_t prev_reg;
	pioc_vec_t filt_reg;

	// Two stages before any logic sees a pin; the raw level feeds the peripherals unfiltered.
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			sync1_reg <= `PIOC_RST_ZERO;
			sync2_reg <= `PIOC_RST_ZERO;
		end else begin
			sync1_reg <= pad_in;
			sync2_reg <= sync1_reg;
		end
	end

	// A filtered line takes a new level only after two equal samples, which costs one
	// cycle of latency and rejects any pulse that is seen in one sample only.
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			prev_reg <= `PIOC_RST_ZERO;
			filt_reg <= `PIOC_RST_ZERO;
		end else if (io.clk_en) begin
			prev_reg <= sync2_reg;
			filt_reg <= (io.filt_en & (sync2_reg ~^ prev_reg) & sync2_reg) |
				(io.filt_en & (sync2_reg ^ prev_reg) & filt_reg) |
				(~io.filt_en & sync2_reg);
		end
	end

	assign io.raw = sync2_reg;
	assign io.filt = filt_reg;

endmodule : pioc_in_filter

//--- core/pioc_chg_detect.sv
`include "pioc_defines.svh"

// Input change detector: compares two successive filtered samples per line.
module pioc_chg_detect
	import pioc_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	pioc_in_if.det_mp io
);

	pioc_vec_t last_reg;
	logic primed_reg;

	// The first sample after reset only primes the history, so no false change is seen.
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			last_reg <= `PIOC_RST_ZERO;
			primed_reg <= 1'b0;
		end else if (io.clk_en) begin
			last_reg <= io.filt;
			primed_reg <= 1'b1;
		end
	end

	// Change pulses exist only while the controller clock runs.
	assign io.chg = (io.clk_en && primed_reg) ? (io.filt ^ last_reg) : `PIOC_RST_ZERO;

endmodule : pioc_chg_detect

//--- core/pioc_top.sv
// The plain strobed port and the address map were chosen for this implementation.
`include "pioc_defines.svh"

module pioc_top
	import pioc_pkg::*;
#(
	parameter pioc_vec_t LINES = `PIOC_ALL_LINES,
	parameter pioc_vec_t OWN_RESET = `PIOC_RST_OWN
)
(
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	input wire logic ctl_clk_en_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	input wire pioc_vec_t pad_in,
	output pioc_vec_t pad_out,
	output pioc_vec_t pad_oe_out,
	output pioc_vec_t pullup_en_out,
	input wire pioc_vec_t per_a_data_in,
	input wire pioc_vec_t per_a_oe_in,
	input wire pioc_vec_t per_b_data_in,
	input wire pioc_vec_t per_b_oe_in,
	output pioc_vec_t per_pin_out,
	output logic irq_out
);

	pioc_vec_t own_reg;
	pioc_vec_t sel_reg;
	pioc_vec_t oe_reg;
	pioc_vec_t od_reg;
	pioc_vec_t ow_reg;
	pioc_vec_t md_reg;
	pioc_vec_t flt_reg;
	pioc_vec_t imr_reg;
	pioc_vec_t isr_reg;
	pioc_vec_t pu_reg;
	pioc_vec_t pin_reg;
	pioc_vec_t pad_out_reg;
	pioc_vec_t pad_oe_reg;
	pioc_vec_t per_pin_reg;
	pioc_vec_t pu_out_reg;
	pioc_vec_t od_next;
	pioc_vec_t isr_next;
	pioc_vec_t drv_data;
	pioc_vec_t drv_oe;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic irq_reg;
	logic isr_read;

	pioc_in_if in_if ();

	// Synchroniser and glitch filter for all lines.
	pioc_in_filter u_filter (
		.core_clk_in(core_clk_in),
		.rst_b_in(rst_b_in),
		.pad_in(pad_in),
		.io(in_if.filt_mp)
	);

	// Change detector on the filtered levels.
	pioc_chg_detect u_detect (
		.core_clk_in(core_clk_in),
		.rst_b_in(rst_b_in),
		.io(in_if.det_mp)
	);

	assign in_if.filt_en = flt_reg;
	assign in_if.clk_en = ctl_clk_en_in;

	// Write decode helper.
	function automatic logic wr_hit(input logic [7:0] off);
		return reg_wr_in && (reg_addr_in == off);
	endfunction : wr_hit

	// Ownership and peripheral select; writes need no controller clock.
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			own_reg <= OWN_RESET & LINES;
			sel_reg <= `PIOC_RST_ZERO;
		end else begin
			own_reg <= pioc_setclr(own_reg, wr_hit(`PIOC_OFF_OWN_SET),
				wr_hit(`PIOC_OFF_OWN_CLR), reg_wdata_in, LINES);
			sel_reg <= pioc_setclr(sel_reg, wr_hit(`PIOC_OFF_SEL_B),
				wr_hit(`PIOC_OFF_SEL_A), reg_wdata_in, LINES);
		end
	end

	// Output enable status is kept whatever owns the line.
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			oe_reg <= `PIOC_RST_ZERO;
		end else begin
			oe_reg <= pioc_setclr(oe_reg, wr_hit(`PIOC_OFF_OE_SET),
				wr_hit(`PIOC_OFF_OE_CLR), reg_wdata_in, LINES);
		end
	end

	// Output data: set/clear writes, plus direct writes through the authorisation mask.
	always_comb begin
		od_next = pioc_setclr(od_reg, wr_hit(`PIOC_OFF_OD_SET),
			wr_hit(`PIOC_OFF_OD_CLR), reg_wdata_in, LINES);
		if (wr_hit(`PIOC_OFF_OD_STS)) begin
			od_next = (od_reg & ~(ow_reg & LINES)) | (reg_wdata_in & ow_reg & LINES);
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			od_reg <= `PIOC_RST_ZERO;
		end else begin
			od_reg <= od_next;
		end
	end

	// Authorisation mask starts cleared so direct writes are inert until enabled.
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			ow_reg <= `PIOC_RST_ZERO;
		end else begin
			ow_reg <= pioc_setclr(ow_reg, wr_hit(`PIOC_OFF_OW_SET),
				wr_hit(`PIOC_OFF_OW_CLR), reg_wdata_in, LINES);
		end
	end

	// Open-drain, filter, pull-up and interrupt mask status.
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			md_reg <= `PIOC_RST_ZERO;
			flt_reg <= `PIOC_RST_ZERO;
			pu_reg <= `PIOC_RST_ZERO;
			imr_reg <= `PIOC_RST_ZERO;
		end else begin
			md_reg <= pioc_setclr(md_reg, wr_hit(`PIOC_OFF_MD_SET),
				wr_hit(`PIOC_OFF_MD_CLR), reg_wdata_in, LINES);
			flt_reg <= pioc_setclr(flt_reg, wr_hit(`PIOC_OFF_FLT_SET),
				wr_hit(`PIOC_OFF_FLT_CLR), reg_wdata_in, LINES);
			pu_reg <= pioc_setclr(pu_reg, wr_hit(`PIOC_OFF_PU_DIS),
				wr_hit(`PIOC_OFF_PU_EN), reg_wdata_in, LINES);
			imr_reg <= pioc_setclr(imr_reg, wr_hit(`PIOC_OFF_IRQ_EN),
				wr_hit(`PIOC_OFF_IRQ_DIS), reg_wdata_in, LINES);
		end
	end

	// Pull-up enables leave from a flop; the next status is used so no cycle is lost.
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			pu_out_reg <= ~`PIOC_RST_ZERO & LINES;
		end else begin
			pu_out_reg <= ~pioc_setclr(pu_reg, wr_hit(`PIOC_OFF_PU_DIS),
				wr_hit(`PIOC_OFF_PU_EN), reg_wdata_in, LINES) & LINES;
		end
	end

	// Drive selection: controller or the chosen peripheral.
	always_comb begin
		drv_data = (own_reg & od_reg) |
			(~own_reg & ~sel_reg & per_a_data_in) |
			(~own_reg & sel_reg & per_b_data_in);
		drv_oe = (own_reg & oe_reg) |
			(~own_reg & ~sel_reg & per_a_oe_in) |
			(~own_reg & sel_reg & per_b_oe_in);
	end

	// Pads are registered; an open-drain line releases instead of driving high.
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			pad_out_reg <= `PIOC_RST_ZERO;
			pad_oe_reg <= `PIOC_RST_ZERO;
		end else begin
			pad_out_reg <= drv_data & LINES;
			pad_oe_reg <= drv_oe & ~(md_reg & drv_data) & LINES;
		end
	end

	// Peripherals see the synchronised pin, never the filtered one.
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			per_pin_reg <= `PIOC_RST_ZERO;
		end else begin
			per_pin_reg <= in_if.raw & LINES;
		end
	end

	// Pin level readback freezes while the controller clock is off.
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			pin_reg <= `PIOC_RST_ZERO;
		end else if (ctl_clk_en_in) begin
			pin_reg <= in_if.filt & LINES;
		end
	end

	// Interrupt status: a change arriving with the clearing read still sets its bit.
	assign isr_read = reg_rd_in && (reg_addr_in == `PIOC_OFF_IRQ_STS);

	always_comb begin
		isr_next = isr_reg;
		if (isr_read) begin
			isr_next = `PIOC_RST_ZERO;
		end
		isr_next = isr_next | (in_if.chg & LINES);
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			isr_reg <= `PIOC_RST_ZERO;
			irq_reg <= 1'b0;
		end else begin
			isr_reg <= isr_next;
			irq_reg <= |(isr_next & imr_reg);
		end
	end

	// Read mux; unmapped and write-only offsets read zero.
	always_comb begin
		rdata_next = `PIOC_RST_ZERO;
		unique case (reg_addr_in)
			`PIOC_OFF_OWN_STS: rdata_next = own_reg;
			`PIOC_OFF_OE_STS: rdata_next = oe_reg;
			`PIOC_OFF_FLT_STS: rdata_next = flt_reg;
			`PIOC_OFF_OD_STS: rdata_next = od_reg;
			`PIOC_OFF_PIN_STS: rdata_next = pin_reg;
			`PIOC_OFF_IRQ_MSK: rdata_next = imr_reg;
			`PIOC_OFF_IRQ_STS: rdata_next = isr_reg;
			`PIOC_OFF_MD_STS: rdata_next = md_reg;
			`PIOC_OFF_PU_STS: rdata_next = pu_reg;
			`PIOC_OFF_SEL_STS: rdata_next = sel_reg;
			`PIOC_OFF_OW_STS: rdata_next = ow_reg;
			default: rdata_next = `PIOC_RST_ZERO;
		endcase
	end

	// Read data stands only in the cycle after the strobe.
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			rdata_reg <= `PIOC_RST_ZERO;
		end else if (reg_rd_in) begin
			rdata_reg <= rdata_next & LINES;
		end else begin
			rdata_reg <= `PIOC_RST_ZERO;
		end
	end

	assign reg_rdata_out = rdata_reg;
	assign pad_out = pad_out_reg;
	assign pad_oe_out = pad_oe_reg;
	assign pullup_en_out = pu_out_reg;
	assign per_pin_out = per_pin_reg;
	assign irq_out = irq_reg;

	// Checks on the behaviour above.
	a_odsr_auth_mask: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		(reg_wr_in && reg_addr_in == `PIOC_OFF_OD_STS) |=>
		((od_reg ^ $past(od_reg)) & ~$past(ow_reg)) == `PIOC_RST_ZERO)
		else $error("Unauthorised output data bit changed.");

	a_od_never_high: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		(pad_oe_reg & md_reg & pad_out_reg & ~$past(md_reg)) == `PIOC_RST_ZERO ||
		(pad_oe_reg & $past(md_reg) & pad_out_reg) == `PIOC_RST_ZERO)
		else $error("Open-drain line driven high.");

	a_oe_set_any_own: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		(reg_wr_in && reg_addr_in == `PIOC_OFF_OE_SET) |=>
		((oe_reg & $past(reg_wdata_in) & LINES) == ($past(reg_wdata_in) & LINES)))
		else $error("Output enable set write lost.");

	a_pin_hold_off: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		!ctl_clk_en_in |=> $stable(pin_reg))
		else $error("Pin level changed with clock off.");

	a_isr_clear_read: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		isr_read |=> isr_reg == $past(in_if.chg & LINES))
		else $error("Status read did not clear pending bits.");

	a_irq_follows: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		irq_reg == |($past(isr_next) & $past(imr_reg)) || $rose(rst_b_in))
		else $error("Interrupt output disagrees with status and mask.");

	a_pin_two_cycle: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		(ctl_clk_en_in && $past(ctl_clk_en_in) && flt_reg == `PIOC_RST_ZERO &&
		$past(flt_reg) == `PIOC_RST_ZERO) |=>
		pin_reg == ($past(in_if.raw, 2) & LINES))
		else $error("Unfiltered pin level not tracked.");

	a_owner_drive: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		(own_reg & ~oe_reg) != `PIOC_RST_ZERO |=>
		(pad_oe_out & $past(own_reg & ~oe_reg)) == `PIOC_RST_ZERO)
		else $error("Controller drove a line without output enable.");

	a_rdata_idle: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		!reg_rd_in |=> reg_rdata_out == `PIOC_RST_ZERO)
		else $error("Read data present without a read.");

	a_auth_reset: assert property (@(posedge core_clk_in)
		$rose(rst_b_in) |-> ow_reg == `PIOC_RST_ZERO && md_reg == `PIOC_RST_ZERO)
		else $error("Authorisation or open-drain not cleared at reset.");

	a_filter_reject: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		(ctl_clk_en_in && $past(ctl_clk_en_in)) |=>
		((in_if.filt ^ $past(in_if.filt)) & $past(flt_reg) &
		($past(in_if.raw) ^ $past(in_if.raw, 2))) == `PIOC_RST_ZERO)
		else $error("Filtered line followed a one-sample pulse.");

	a_chg_sets_isr: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		(in_if.chg & LINES) != `PIOC_RST_ZERO |=>
		(isr_reg & $past(in_if.chg & LINES)) == $past(in_if.chg & LINES))
		else $error("Detected change did not set its status bit.");

	a_imr_enable: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		(reg_wr_in && reg_addr_in == `PIOC_OFF_IRQ_EN) |=>
		((imr_reg & $past(reg_wdata_in) & LINES) == ($past(reg_wdata_in) & LINES)))
		else $error("Interrupt enable write lost.");

	a_periph_route: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		rst_b_in |=>
		(((pad_out_reg ^ $past(per_a_data_in)) & $past(~own_reg & ~sel_reg & LINES)) |
		((pad_out_reg ^ $past(per_b_data_in)) & $past(~own_reg & sel_reg & LINES))) ==
		`PIOC_RST_ZERO)
		else $error("Peripheral drive data not routed by select.");

endmodule : pioc_top

//--- verif/pioc_pin_model.sv
// Board side of the 32 lines: external drivers plus the on-chip pull-ups.
module pioc_pin_model
	import pioc_pkg::*;
(
	input wire pioc_vec_t pad_out_in,
	input wire pioc_vec_t pad_oe_in,
	input wire pioc_vec_t pullup_en_in,
	input wire pioc_vec_t ext_oe_in,
	input wire pioc_vec_t ext_val_in,
	output pioc_vec_t level_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// A released line without pull-up shows the inverse of the last data, so a kept level is
	// never mistaken for a real one.
	assign level_out = (pad_oe_in & pad_out_in) | (~pad_oe_in & ext_oe_in & ext_val_in)
		| (~pad_oe_in & ~ext_oe_in & (pullup_en_in | ~pad_out_in));
endmodule : pioc_pin_model

//--- verif/testbench.sv
`include "pioc_defines.svh"

module testbench
	import pioc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic core_clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic ctl_clk_en_in = 1'b1;
	logic [7:0] reg_addr_in = 8'h00;
	logic [31:0] reg_wdata_in = 32'h0000_0000;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic [31:0] reg_rdata_out;
	logic irq_out;
	pioc_vec_t pad_in, pad_out, pad_oe_out, pullup_en_out, per_pin_out;
	pioc_vec_t per_a_data_in = '0, per_a_oe_in = '0, per_b_data_in = '0, per_b_oe_in = '0;
	// The board holds every line low at first, so reset leaves no change pending.
	pioc_vec_t ext_oe = '1, ext_val = '0;
	// Model state: one word per register, indexed by byte offset divided by four.
	pioc_vec_t m [0:63];
	int mismatches = 0, samples_checked = 0, cycles = 0;
	pioc_vec_t v, k, lvl;
	logic [7:0] sts [10] = '{8'h08, 8'h18, 8'h28, 8'h38, 8'h48, 8'h4C, 8'h58, 8'h68, 8'h78, 8'hA8};
	logic [7:0] pairs [7] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'hA0};

	pioc_top #(.LINES(`PIOC_ALL_LINES), .OWN_RESET(`PIOC_RST_OWN)) dut (
		.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .ctl_clk_en_in(ctl_clk_en_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .pad_in(pad_in),
		.pad_out(pad_out), .pad_oe_out(pad_oe_out), .pullup_en_out(pullup_en_out),
		.per_a_data_in(per_a_data_in), .per_a_oe_in(per_a_oe_in),
		.per_b_data_in(per_b_data_in), .per_b_oe_in(per_b_oe_in),
		.per_pin_out(per_pin_out), .irq_out(irq_out));

	pioc_pin_model pins (.pad_out_in(pad_out), .pad_oe_in(pad_oe_out),
		.pullup_en_in(pullup_en_out), .ext_oe_in(ext_oe), .ext_val_in(ext_val),
		.level_out(pad_in));

	// Free-running 50 MHz clock.
	initial begin
		forever #10 core_clk_in = ~core_clk_in;
	end

	// Hang guard: the whole run needs about 350 cycles.
	always @(posedge core_clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			results();
		end
	end

	task automatic results();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : results

	task automatic chk_reg(input string n, input pioc_vec_t e, input pioc_vec_t g);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk_reg

	// Pad compare; the mask hides bits that carry no meaning, such as data on undriven lines.
	task automatic chk_pad(input string n, input pioc_vec_t e, input pioc_vec_t g,
		input pioc_vec_t k);
		samples_checked++;
		if ((g & k) !== (e & k)) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, e & k, g & k);
		end
	endtask : chk_pad

	task automatic wr(input logic [7:0] a, input pioc_vec_t x);
		@(posedge core_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= x;
		reg_wr_in <= 1'b1;
		@(posedge core_clk_in);
		reg_wr_in <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe; they are taken at the edge that
	// closes that cycle, before the design clears them.
	task automatic rd(input logic [7:0] a, output pioc_vec_t x);
		@(posedge core_clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge core_clk_in);
		reg_rd_in <= 1'b0;
		@(posedge core_clk_in);
		x = reg_rdata_out;
	endtask : rd

	// Write through the bus and apply the same write to the model.
	task automatic mwr(input logic [7:0] a, input pioc_vec_t x);
		int s;
		s = a >> 2;
		wr(a, x);
		if (a == `PIOC_OFF_OD_STS) begin
			m[14] = (m[14] & ~m[42]) | (x & m[42]);
		end else if (a == `PIOC_OFF_SEL_A) begin
			m[30] &= ~x;
		end else if (a == `PIOC_OFF_SEL_B) begin
			m[30] |= x;
		end else if (a[3:2] == 2'b00) begin
			m[s + 2] |= x;
		end else if (a[3:2] == 2'b01) begin
			m[s + 1] &= ~x;
		end
	endtask : mwr

	task automatic mrd(input logic [7:0] a);
		rd(a, v);
		chk_reg($sformatf("reg %h", a), m[a >> 2], v);
	endtask : mrd

	// Selected drive enable or data per line, after ownership and A/B choice; open drain masks the enable only.
	function automatic pioc_vec_t drive(input logic want_oe);
		pioc_vec_t so, sd;
		so = (m[2] & m[6]) | (~m[2] & ((m[30] & per_b_oe_in) | (~m[30] & per_a_oe_in)));
		sd = (m[2] & m[14]) | (~m[2] & ((m[30] & per_b_data_in) | (~m[30] & per_a_data_in)));
		return want_oe ? (so & ~(m[22] & sd)) : sd;
	endfunction : drive

	task automatic check_pads();
		k = drive(1'b1);
		lvl = (k & drive(1'b0)) | (~k & ext_oe & ext_val) | (~k & ~ext_oe);
		chk_pad("pad_oe", k, pad_oe_out, '1);
		chk_pad("pad_out", drive(1'b0), pad_out, k);
		chk_pad("pullup", ~m[26], pullup_en_out, '1);
		chk_pad("per_pin", lvl, per_pin_out, '1);
		rd(`PIOC_OFF_PIN_STS, v);
		chk_reg("pin_sts", lvl, v);
	endtask : check_pads

	// Main sequence; pull-ups stay on so every released line that the board leaves undriven reads high.
	initial begin
		v = $urandom(32'h755395CE);
		foreach (m[i]) m[i] = '0;
		repeat (12) @(posedge core_clk_in);
		rst_b_in <= 1'b1;
		foreach (sts[i]) mrd(sts[i]);
		mrd(8'h0C);
		mrd(`PIOC_OFF_OE_SET);
		mwr(`PIOC_OFF_OD_STS, $urandom);
		mrd(`PIOC_OFF_OD_STS);
		foreach (pairs[i]) begin
			mwr(pairs[i], $urandom);
			mwr(pairs[i] + 8'h04, $urandom);
			mrd(pairs[i] + 8'h08);
		end
		mwr(`PIOC_OFF_SEL_B, $urandom);
		mwr(`PIOC_OFF_SEL_A, $urandom);
		mrd(`PIOC_OFF_SEL_STS);
		mwr(`PIOC_OFF_OD_STS, $urandom);
		mrd(`PIOC_OFF_OD_STS);
		repeat (5) begin
			per_a_data_in <= $urandom;
			per_a_oe_in <= $urandom;
			per_b_data_in <= $urandom;
			per_b_oe_in <= $urandom;
			mwr(`PIOC_OFF_OWN_SET, $urandom);
			mwr(`PIOC_OFF_OWN_CLR, $urandom);
			mwr(`PIOC_OFF_OE_SET, $urandom);
			mwr(`PIOC_OFF_MD_CLR, $urandom);
			mwr(`PIOC_OFF_OD_SET, $urandom);
			mwr(`PIOC_OFF_OD_CLR, $urandom);
			mwr(`PIOC_OFF_OW_SET, $urandom);
			mwr(`PIOC_OFF_OD_STS, $urandom);
			mwr(`PIOC_OFF_MD_SET, $urandom);
			ext_oe <= $urandom & ~drive(1'b1);
			ext_val <= $urandom;
			repeat (8) @(posedge core_clk_in);
			check_pads();
		end
		ctl_clk_en_in <= 1'b0;
		repeat (3) @(posedge core_clk_in);
		ext_val <= ~ext_val;
		repeat (8) @(posedge core_clk_in);
		rd(`PIOC_OFF_PIN_STS, v);
		chk_reg("pin_sts_frozen", lvl, v);
		ctl_clk_en_in <= 1'b1;
		// Interrupt flow: all lines become inputs driven from the board.
		mwr(`PIOC_OFF_OWN_SET, '1);
		mwr(`PIOC_OFF_OE_CLR, '1);
		ext_oe <= '1;
		ext_val <= '0;
		repeat (10) @(posedge core_clk_in);
		rd(`PIOC_OFF_IRQ_STS, v);
		mwr(`PIOC_OFF_IRQ_DIS, '1);
		mwr(`PIOC_OFF_IRQ_EN, $urandom);
		repeat (3) begin
			k = $urandom;
			ext_val <= ext_val ^ k;
			repeat (10) @(posedge core_clk_in);
			chk_pad("irq", {31'h0, |(k & m[18])}, {31'h0, irq_out}, '1);
			rd(`PIOC_OFF_IRQ_STS, v);
			chk_reg("irq_sts", k, v);
			rd(`PIOC_OFF_IRQ_STS, v);
			chk_reg("irq_sts_cleared", '0, v);
			repeat (2) @(posedge core_clk_in);
			chk_pad("irq_low", '0, {31'h0, irq_out}, '1);
		end
		results();
	end
endmodule : testbench
